// [mmt_core.sv]
// Management control and status sequencer of a four-lane module
//
// The implementer's own choices: the address map and register access over Avalon-MM.
`timescale 1ns/10ps
module mmt_core #(
	parameter int unsigned INIT_CYC   = mmt_pkg::T_INIT_MS * mmt_pkg::CYC_PER_MS,
	parameter int unsigned SERIAL_CYC = mmt_pkg::T_SERIAL_MS * mmt_pkg::CYC_PER_MS,
	parameter int unsigned RXSQ_CYC   = mmt_pkg::T_RXSQ_US * mmt_pkg::CYC_PER_US,
	parameter int unsigned TXSQ_CYC   = mmt_pkg::T_TXSQ_MS * mmt_pkg::CYC_PER_MS
) (
	// Clock and reset
	input  wire logic               clk_i,
	input  wire logic               reset_i,
	// Avalon-MM slave
	input  wire logic [7:0]         address_i,
	input  wire logic               read_i,
	input  wire logic               write_i,
	input  wire logic [3:0]         byteenable_i,
	input  wire logic [31:0]        writedata_i,
	output logic      [31:0]        readdata_o,
	output logic                    waitrequest_o,
	// Sideband pins and lane status
	input  wire mmt_pkg::mmt_pins_s pins_i,
	// Module outputs
	output logic                    host_attention_n_o,
	output logic                    serial_respond_o,
	output logic                    power_low_o,
	output mmt_pkg::mmt_lane_s      lanes_o
);

	typedef struct packed {
		mmt_pkg::mmt_state_e st;
		logic [31:0]         cnt;
		logic [7:0]          low_cnt;
		logic                not_ready;
		logic                ser_ready;
		logic                done_flag;
		mmt_pkg::mmt_ctrl_s  ctrl;
		logic [15:0]         mask;
		logic [15:0]         flags;
		logic [15:0]         cond;
		logic                scl;
		logic                sda;
		logic [7:0]          stops;
		logic                waitreq;
		logic [31:0]         rdata;
		logic                attn_n;
		logic                ser_en;
		logic                pwr_low;
		mmt_pkg::mmt_lane_s  lanes;
	} mmt_core_s;

	localparam mmt_core_s CORE_RST = '{
		st:        mmt_pkg::ST_INIT,
		not_ready: 1'b1,
		ctrl:      mmt_pkg::CTRL_RST,
		mask:      mmt_pkg::MASK_RST,
		scl:       1'b1,
		sda:       1'b1,
		waitreq:   1'b1,
		attn_n:    1'b1,
		pwr_low:   1'b1,
		default:   '0
	};

	mmt_core_s          s;
	mmt_core_s          n;
	mmt_pkg::mmt_pins_s sy;
	logic [24:0]        sy_vec;
	logic [3:0]         rx_sq;
	logic [3:0]         tx_sq;
	logic               req;
	logic               acc;
	logic               lp;
	logic               pin_reset;
	logic [31:0]        be_mask;
	logic [15:0]        cond_now;
	logic [15:0]        rise;
	logic [31:0]        status_word;
	logic               run_lp;

	// Every pin crosses into the clock domain first
	mmt_sync #(
		.W       (25),
		.RST_VAL (mmt_pkg::PINS_RST)
	) u_sync (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.d_i     (pins_i),
		.q_o     (sy_vec)
	);

	assign sy = mmt_pkg::mmt_pins_s'(sy_vec);

	// Squelch detectors, one pair per lane
	for (genvar g = 0; g < mmt_pkg::N_LANE; g++) begin : g_lane
		mmt_settle #(
			.CYC     (RXSQ_CYC)
		) u_rx_sq (
			.clk_i   (clk_i),
			.reset_i (reset_i),
			.level_i (sy.rx_los[g]),
			.level_o (rx_sq[g])
		);
		mmt_settle #(
			.CYC     (TXSQ_CYC)
		) u_tx_sq (
			.clk_i   (clk_i),
			.reset_i (reset_i),
			.level_i (sy.tx_lost[g]),
			.level_o (tx_sq[g])
		);
	end

	always_comb begin
		n = s;
		req = read_i | write_i;
		acc = req & ~s.waitreq;
		be_mask = {{8{byteenable_i[3]}}, {8{byteenable_i[2]}}, {8{byteenable_i[1]}}, {8{byteenable_i[0]}}};
		cond_now = '0;
		cond_now[mmt_pkg::FLG_LOS_LSB +: 4] = sy.rx_los;
		cond_now[mmt_pkg::FLG_FAULT_LSB +: 4] = sy.tx_fault;
		cond_now[mmt_pkg::FLG_ALARM_LSB +: 8] = sy.alarm;
		rise = cond_now & ~s.cond;
		lp = sy.low_power_pin | s.ctrl.pdown;
		pin_reset = ~sy.module_reset_n & (s.low_cnt == mmt_pkg::RESET_MIN_CNT);
		run_lp = (s.st == mmt_pkg::ST_RUN) & ~lp;

		status_word = '0;
		status_word[mmt_pkg::STAT_NOT_READY] = s.not_ready;
		status_word[mmt_pkg::STAT_ATTN] = s.attn_n;
		status_word[mmt_pkg::STAT_PAGED] = 1'b1;
		status_word[mmt_pkg::STAT_SERIAL] = s.ser_ready;
		status_word[mmt_pkg::STAT_LOW_PWR] = s.pwr_low;
		status_word[mmt_pkg::STAT_STOPS_LSB +: 8] = s.stops;

		// One wait cycle per request; data stands while waitrequest is low
		n.waitreq = ~(req & s.waitreq);
		if (read_i & s.waitreq) begin
			case (address_i)
				mmt_pkg::ADDR_STATUS: n.rdata = status_word;
				mmt_pkg::ADDR_FLAGS:  n.rdata = {16'h0000, s.flags};
				mmt_pkg::ADDR_CTRL:   n.rdata = {18'h00000, s.ctrl};
				mmt_pkg::ADDR_MASK:   n.rdata = {16'h0000, s.mask};
				default:              n.rdata = 32'h00000000;
			endcase
		end

		// writes act at the accepting edge
		if (acc & write_i & (address_i == mmt_pkg::ADDR_CTRL)) begin
			n.ctrl = mmt_pkg::mmt_ctrl_s'(14'((32'(s.ctrl) & ~be_mask) | (writedata_i & be_mask)));
		end
		if (acc & write_i & (address_i == mmt_pkg::ADDR_MASK)) begin
			n.mask = 16'(({16'h0000, s.mask} & ~be_mask) | (writedata_i & be_mask));
		end

		// clear on read, set wins below
		n.cond = cond_now;
		if (acc & read_i & (address_i == mmt_pkg::ADDR_FLAGS)) begin
			n.flags = '0;
		end
		if (s.st == mmt_pkg::ST_RUN) begin
			n.flags = n.flags | rise;
		end
		if (acc & read_i & (address_i == mmt_pkg::ADDR_STATUS)) begin
			n.done_flag = 1'b0;
		end

		if (!sy.module_reset_n) begin
			if (s.low_cnt != mmt_pkg::RESET_MIN_CNT) begin
				n.low_cnt = s.low_cnt + 8'h01;
			end
		end else begin
			n.low_cnt = '0;
		end

		case (s.st)
			mmt_pkg::ST_HOLD: begin
				if (sy.module_reset_n) begin
					n.st = mmt_pkg::ST_INIT;
					n.cnt = '0;
				end
			end
			mmt_pkg::ST_INIT: begin
				n.cnt = s.cnt + 32'h00000001;
				if (s.cnt == 32'(SERIAL_CYC - 1)) begin
					n.ser_ready = 1'b1;
				end
				if (s.cnt == 32'(INIT_CYC - 1)) begin
					n.st = mmt_pkg::ST_RUN;
					n.not_ready = 1'b0;
					n.ser_ready = 1'b1;
					n.done_flag = 1'b1;
				end
			end
			mmt_pkg::ST_RUN: begin
				n.st = mmt_pkg::ST_RUN;
			end
			default: begin
				n.st = mmt_pkg::ST_HOLD;
			end
		endcase

		if (pin_reset) begin
			n.st = mmt_pkg::ST_HOLD;
			n.cnt = '0;
			n.not_ready = 1'b1;
			n.ser_ready = 1'b0;
			n.done_flag = 1'b0;
			n.ctrl = mmt_pkg::CTRL_RST;
			n.mask = mmt_pkg::MASK_RST;
			n.flags = '0;
		end

		n.ser_en = s.ser_ready & ~sy.module_select_n;
		n.scl = sy.scl;
		n.sda = sy.sda;
		// Stop condition seen while selected adds one to the stop count
		if (s.ser_en & s.scl & sy.scl & ~s.sda & sy.sda) begin
			n.stops = s.stops + 8'h01;
		end

		n.pwr_low = lp | (s.st != mmt_pkg::ST_RUN);
		n.attn_n = ~((|(s.flags & ~s.mask)) | s.done_flag);
		n.lanes.rate_sel = s.ctrl.rate_sel;
		n.lanes.tx_en = {4{run_lp}} & ~s.ctrl.tx_dis & ~(tx_sq & {4{~s.ctrl.sq_dis}});
		n.lanes.rx_en = {4{run_lp}} & ~s.ctrl.rx_dis & ~(rx_sq & {4{~s.ctrl.sq_dis}});
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			s <= CORE_RST;
		end else begin
			s <= n;
		end
	end

	assign readdata_o = s.rdata;
	assign waitrequest_o = s.waitreq;
	assign host_attention_n_o = s.attn_n;
	assign serial_respond_o = s.ser_en;
	assign power_low_o = s.pwr_low;
	assign lanes_o = s.lanes;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);

	AST_RESET_MIN: assert property ($rose(s.st == mmt_pkg::ST_HOLD) |->
		$past(s.low_cnt) == mmt_pkg::RESET_MIN_CNT && !$past(sy.module_reset_n))
		else $error("reset entered before minimum low time");

	AST_INIT_DONE: assert property ($fell(s.not_ready) |->
		$past(s.cnt) == 32'(INIT_CYC - 1) ##1 !host_attention_n_o)
		else $error("init completion not counted or not signalled");

	AST_SERIAL_SEL: assert property (serial_respond_o |->
		$past(s.ser_ready) && !$past(sy.module_select_n))
		else $error("serial answer while deselected or not ready");

	AST_LP_ENTRY: assert property ($rose(sy.low_power_pin) |-> ##1 power_low_o)
		else $error("low power not entered");

	AST_PDOWN: assert property ($rose(s.ctrl.pdown) |-> ##1 power_low_o [*2])
		else $error("software power-down not honoured");

	AST_FLAG_ATTN: assert property ((s.st == mmt_pkg::ST_RUN && sy.module_reset_n &&
		|(rise & ~s.mask)) |-> ##[1:2] !host_attention_n_o)
		else $error("attention not asserted after flag event");

	AST_SET_WINS: assert property ((acc && read_i && address_i == mmt_pkg::ADDR_FLAGS &&
		s.st == mmt_pkg::ST_RUN && sy.module_reset_n && |rise) |=> s.flags != 16'h0000)
		else $error("flag event lost during clearing read");

	AST_READ_CLEAR: assert property ((acc && read_i && address_i == mmt_pkg::ADDR_FLAGS &&
		rise == 16'h0000) |=> s.flags == 16'h0000)
		else $error("flags not cleared by read");

	AST_MASK_GATE: assert property (((s.flags & ~s.mask) == 16'h0000 && !s.done_flag) |=>
		host_attention_n_o)
		else $error("masked flags still drive attention");

	AST_TX_DIS: assert property (s.ctrl.tx_dis[0] |=> !lanes_o.tx_en[0])
		else $error("disabled transmitter still enabled");

	AST_RATE: assert property ($changed(s.ctrl.rate_sel) |=>
		lanes_o.rate_sel == $past(s.ctrl.rate_sel))
		else $error("rate select not applied");

	AST_WAIT: assert property ((req && waitrequest_o) |=> !waitrequest_o)
		else $error("bus request not answered in one cycle");

endmodule

// [mmt_pkg.sv]
// Constants and carrier types for the module management sequencer
package mmt_pkg;

	// Clock rate and times as specified
	localparam int unsigned CLK_MHZ        = 125;
	localparam int unsigned CYC_PER_US     = CLK_MHZ;
	localparam int unsigned CYC_PER_MS     = CLK_MHZ * 1000;
	localparam int unsigned T_INIT_MS      = 2000;
	localparam int unsigned T_SERIAL_MS    = 2000;
	localparam int unsigned T_RESET_MIN_US = 2;
	localparam int unsigned T_RXSQ_US      = 80;
	localparam int unsigned T_TXSQ_MS      = 400;
	localparam int unsigned RESET_MIN_CYC  = T_RESET_MIN_US * CYC_PER_US;
	localparam logic [7:0]  RESET_MIN_CNT  = 8'(RESET_MIN_CYC);

	// Sizes
	localparam int unsigned N_LANE  = 4;
	localparam int unsigned N_ALARM = 8;

	// Register byte offsets
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_FLAGS  = 8'h04;
	localparam logic [7:0] ADDR_CTRL   = 8'h08;
	localparam logic [7:0] ADDR_MASK   = 8'h0C;

	// Status word fields
	localparam int unsigned STAT_NOT_READY = 0;
	localparam int unsigned STAT_ATTN      = 1;
	localparam int unsigned STAT_PAGED     = 2;
	localparam int unsigned STAT_SERIAL    = 3;
	localparam int unsigned STAT_LOW_PWR   = 4;
	localparam int unsigned STAT_STOPS_LSB = 8;

	// Flag and mask word fields
	localparam int unsigned FLG_LOS_LSB   = 0;
	localparam int unsigned FLG_FAULT_LSB = 4;
	localparam int unsigned FLG_ALARM_LSB = 8;

	// Reset values
	localparam logic [13:0] CTRL_RST = 14'h0000;
	localparam logic [15:0] MASK_RST = 16'h0000;
	localparam logic [24:0] PINS_RST = 25'h000001B;

	typedef enum logic [1:0] {
		ST_HOLD = 2'b00,
		ST_INIT = 2'b01,
		ST_RUN  = 2'b10
	} mmt_state_e;

	typedef struct packed {
		logic [3:0] rate_sel;
		logic       sq_dis;
		logic       pdown;
		logic [3:0] rx_dis;
		logic [3:0] tx_dis;
	} mmt_ctrl_s;

	typedef struct packed {
		logic [7:0] alarm;
		logic [3:0] tx_lost;
		logic [3:0] tx_fault;
		logic [3:0] rx_los;
		logic       scl;
		logic       sda;
		logic       low_power_pin;
		logic       module_select_n;
		logic       module_reset_n;
	} mmt_pins_s;

	typedef struct packed {
		logic [3:0] tx_en;
		logic [3:0] rx_en;
		logic [3:0] rate_sel;
	} mmt_lane_s;

endpackage

// [mmt_sync.sv]
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/10ps
module mmt_sync #(
	parameter int unsigned     W       = 1,
	parameter logic [W-1:0]    RST_VAL = '0
) (
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         reset_i,
	// Data
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} mmt_sync_s;

	mmt_sync_s s;
	mmt_sync_s n;

	always_comb begin
		n = s;
		n.s1 = d_i;
		n.s2 = s.s1;
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			s <= '{s1: RST_VAL, s2: RST_VAL};
		end else begin
			s <= n;
		end
	end

	assign q_o = s.s2;

endmodule

// [mmt_settle.sv]
// Level follower that moves only after a fixed settle count
`timescale 1ns/10ps
module mmt_settle #(
	parameter int unsigned CYC = 1
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic reset_i,
	// Level
	input  wire logic level_i,
	output logic      level_o
);

	typedef struct packed {
		logic [31:0] cnt;
		logic        lvl;
	} mmt_settle_s;

	mmt_settle_s s;
	mmt_settle_s n;

	// Short glitches restart the count, so the output never chatters
	always_comb begin
		n = s;
		if (level_i == s.lvl) begin
			n.cnt = '0;
		end else if (s.cnt == 32'(CYC - 1)) begin
			n.lvl = level_i;
			n.cnt = '0;
		end else begin
			n.cnt = s.cnt + 32'h00000001;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign level_o = s.lvl;

endmodule

// [mmt_host_model.sv]
// Host controller model driving the sideband pins and the 2-wire bus
`timescale 1ns/10ps
module mmt_host_model (
	// Clock
	input  wire logic clk_i,
	// Host side pins
	output logic      scl_o,
	output logic      sda_o,
	output logic      low_power_pin_o,
	output logic      module_select_n_o,
	output logic      module_reset_n_o
);
	// Pull-ups hold the bus high between frames
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
		low_power_pin_o = 1'b0;
		module_select_n_o = 1'b1;
		module_reset_n_o = 1'b1;
	end

	task automatic lp(input logic v);
		@(posedge clk_i);
		low_power_pin_o <= v;
	endtask

	task automatic sel(input logic v);
		@(posedge clk_i);
		module_select_n_o <= v;
		repeat (4) @(posedge clk_i);
	endtask

	// Link clock runs only inside a frame, 80 ns period
	task automatic frame(input int nbits);
		@(posedge clk_i);
		sda_o <= 1'b0;
		repeat (nbits) begin
			repeat (5) @(posedge clk_i);
			scl_o <= 1'b0;
			sda_o <= ~sda_o;
			repeat (5) @(posedge clk_i);
			scl_o <= 1'b1;
		end
		repeat (5) @(posedge clk_i);
		scl_o <= 1'b0;
		sda_o <= 1'b0;
		repeat (5) @(posedge clk_i);
		scl_o <= 1'b1;
		repeat (5) @(posedge clk_i);
		sda_o <= 1'b1;
		repeat (5) @(posedge clk_i);
	endtask

	// reset pin held low n cycles
	task automatic reset_pulse(input int n);
		@(posedge clk_i);
		module_reset_n_o <= 1'b0;
		repeat (n) @(posedge clk_i);
		module_reset_n_o <= 1'b1;
		repeat (5) @(posedge clk_i);
	endtask
endmodule

// [testbench.sv]
// Self-checking bench for the management sequencer
`timescale 1ns/10ps
module testbench;
	logic               clk_i;
	logic               reset_i;
	logic [7:0]         address_i;
	logic               read_i;
	logic               write_i;
	logic [31:0]        writedata_i;
	logic [3:0]         byteenable_i;
	logic [3:0]         be;
	logic [31:0]        readdata_o;
	logic               waitrequest_o;
	logic               host_attention_n_o;
	logic               serial_respond_o;
	logic               power_low_o;
	mmt_pkg::mmt_lane_s lanes_o;
	mmt_pkg::mmt_pins_s pins;
	logic               scl, sda, lpp, seln, rstn;
	logic [15:0]        evt;
	logic [3:0]         txl;
	logic [31:0]        q;
	int                 err_total, n_compared, ctrl, mask, b, seed;

	assign pins = {evt[15:8], txl, evt[7:4], evt[3:0], scl, sda, lpp, seln, rstn};

	mmt_core #(.INIT_CYC(200), .SERIAL_CYC(100), .RXSQ_CYC(20), .TXSQ_CYC(40)) u_mmt_core (
		.clk_i(clk_i), .reset_i(reset_i), .address_i(address_i), .read_i(read_i), .write_i(write_i),
		.byteenable_i(byteenable_i), .writedata_i(writedata_i), .readdata_o(readdata_o),
		.waitrequest_o(waitrequest_o), .pins_i(pins), .host_attention_n_o(host_attention_n_o),
		.serial_respond_o(serial_respond_o), .power_low_o(power_low_o), .lanes_o(lanes_o));

	mmt_host_model u_mmt_host_model (.clk_i(clk_i), .scl_o(scl), .sda_o(sda), .low_power_pin_o(lpp),
		.module_select_n_o(seln), .module_reset_n_o(rstn));

	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	task automatic results();
		if (err_total == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk_w(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic chk_p(input string nm, input logic [11:0] e, input logic [11:0] g);
		n_compared++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask

	// Request held until waitrequest is seen low at an edge
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		address_i <= a;
		read_i <= ~wr;
		write_i <= wr;
		writedata_i <= d;
		byteenable_i <= be;
		// Only the watchdog ends a hung request
		do begin
			@(posedge clk_i);
		end while (waitrequest_o !== 1'b0);
		q = readdata_o;
		read_i <= 1'b0;
		write_i <= 1'b0;
	endtask

	task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk_w(nm, e, q);
	endtask

	task automatic wr_ctrl(input int v);
		int m;
		m = 0;
		// Byte lanes merge into the held control word
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				m = m | (32'hFF << (8 * i));
			end
		end
		ctrl = ((ctrl & ~m) | (v & m)) & 32'h3FFF;
		bus(1'b1, mmt_pkg::ADDR_CTRL, 32'(v));
		repeat (4) @(posedge clk_i);
	endtask

	// Model of lane enables while running
	function automatic logic [11:0] exp_lanes();
		logic [11:0] r;
		logic        pw;
		pw = lpp | ctrl[8];
		r = {8'h00, 4'(ctrl >> 10)};
		for (int i = 0; i < 4; i++) begin
			r[8+i] = !pw && !ctrl[i] && !(txl[i] && !ctrl[9]);
			r[4+i] = !pw && !ctrl[4+i] && !(evt[i] && !ctrl[9]);
		end
		return r;
	endfunction

	task automatic wait_attn(input int lim);
		int n;
		n = 0;
		while (host_attention_n_o !== 1'b0 && n < lim) begin
			@(posedge clk_i);
			n++;
		end
		chk_p("attention_low", 12'h0, 12'(host_attention_n_o));
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	initial begin
		#200000;
		err_total++;
		results();
	end

	initial begin
		seed = 32'h36ae;
		reset_i = 1'b1;
		address_i = 8'h00;
		read_i = 1'b0;
		write_i = 1'b0;
		writedata_i = 32'h0;
		byteenable_i = 4'hF;
		be = 4'hF;
		evt = 16'h0000;
		txl = 4'h0;
		ctrl = 0;
		mask = 0;
		step(8);
		chk_p("reset_outs", 12'h007, 12'({waitrequest_o, host_attention_n_o, power_low_o}));
		chk_p("reset_lanes", 12'h000, lanes_o);
		reset_i <= 1'b0;
		wait_attn(215);
		rd("status_ready", mmt_pkg::ADDR_STATUS, 32'h0000000C);
		step(4);
		chk_p("attention_rel", 12'h001, 12'(host_attention_n_o));
		rd("unmapped", 8'h10, 32'h0);
		u_mmt_host_model.frame(8);
		chk_p("serial_unsel", 12'h000, 12'(serial_respond_o));
		u_mmt_host_model.sel(1'b0);
		chk_p("serial_sel", 12'h001, 12'(serial_respond_o));
		u_mmt_host_model.frame(8);
		rd("status_stops", mmt_pkg::ADDR_STATUS, 32'h0000010E);
		u_mmt_host_model.sel(1'b1);
		for (int i = 0; i < 8; i++) begin
			be = 4'($random(seed));
			wr_ctrl($random(seed));
			rd("ctrl", mmt_pkg::ADDR_CTRL, 32'(ctrl));
			chk_p("lanes", exp_lanes(), lanes_o);
			chk_p("power_low", 12'(ctrl[8]), 12'(power_low_o));
		end
		be = 4'hF;
		wr_ctrl(0);
		for (int i = 0; i < 10; i++) begin
			b = $unsigned($random(seed)) % 16;
			evt[b] <= 1'b1;
			step(8);
			chk_p("attn_flag", 12'h000, 12'(host_attention_n_o));
			rd("flags", mmt_pkg::ADDR_FLAGS, 32'h1 << b);
			step(3);
			chk_p("attn_clear", 12'h001, 12'(host_attention_n_o));
			evt[b] <= 1'b0;
			step(30);
		end
		bus(1'b1, mmt_pkg::ADDR_MASK, 32'h0000FFFF);
		evt <= 16'h0101;
		step(8);
		chk_p("attn_masked", 12'h001, 12'(host_attention_n_o));
		// Rx squelch settles only after its full count
		step(20);
		chk_p("lanes_sq", exp_lanes(), lanes_o);
		wr_ctrl(32'h200);
		chk_p("lanes_sqdis", exp_lanes(), lanes_o);
		bus(1'b1, mmt_pkg::ADDR_MASK, 32'h0);
		step(3);
		chk_p("attn_unmask", 12'h000, 12'(host_attention_n_o));
		rd("flags_m", mmt_pkg::ADDR_FLAGS, 32'h00000101);
		txl <= 4'h6;
		wr_ctrl(0);
		step(50);
		chk_p("lanes_txsq", exp_lanes(), lanes_o);
		evt <= 16'h0;
		txl <= 4'h0;
		step(50);
		chk_p("lanes_restore", exp_lanes(), lanes_o);
		u_mmt_host_model.lp(1'b1);
		step(4);
		chk_p("lp_on", 12'h001, 12'(power_low_o));
		chk_p("lp_lanes", exp_lanes(), lanes_o);
		u_mmt_host_model.lp(1'b0);
		step(4);
		chk_p("lp_off", 12'h000, 12'(power_low_o));
		wr_ctrl(32'h0C11);
		u_mmt_host_model.reset_pulse(100);
		rd("ctrl_kept", mmt_pkg::ADDR_CTRL, 32'h00000C11);
		u_mmt_host_model.reset_pulse(300);
		rd("ctrl_dflt", mmt_pkg::ADDR_CTRL, 32'h0);
		bus(1'b0, mmt_pkg::ADDR_STATUS, 32'h0);
		chk_w("not_ready", 32'h1, q & 32'h1);
		ctrl = 0;
		wait_attn(215);
		bus(1'b0, mmt_pkg::ADDR_STATUS, 32'h0);
		chk_w("ready_again", 32'h0, q & 32'h1);
		results();
	end
endmodule
